// ---- rtl/mrm_pkg.sv ----
// mrm_pkg: constants, types and decode helpers for the mode register
// and address mux block; shared by every design file of the block except mrm_sync.
package mrm_pkg;

  // ==========================================================
  // clock, widths and timing
  localparam int SYS_CLK_NS = 100;
  localparam int ADDR_W = 22;
  localparam int BANK_W = 3;
  localparam int MUX_LINES = 11;
  localparam int TMR_W = 11;
  localparam int SETTLE_CYC = 6;
  localparam int DLL_LOCK_CYC = 1024;
  localparam int IMP_PERIOD_NS = 100000;
  localparam int IMP_PERIOD_CYC = IMP_PERIOD_NS / SYS_CLK_NS;

  // ==========================================================
  // mode bit positions on the address lines
  localparam int M_MX = 5;
  localparam int M_DLL = 7;
  localparam int M_EXT = 8;
  localparam int M_TRM = 9;
  localparam int M_BST = 3;
  localparam int P2_M1 = 3;
  localparam int P2_M2 = 4;
  localparam int P2_M7 = 9;
  localparam logic [1:0] BST_CODE_4 = 2'h1;
  localparam logic [1:0] BST_CODE_8 = 2'h2;
  localparam logic [4:0] TOP_BST2 = 5'h15;
  localparam logic [4:0] TOP_BST4 = 5'h14;
  localparam logic [4:0] TOP_BST8 = 5'h13;

  // first and second phase address bit carried by each mux line
  localparam int PH1_BIT [MUX_LINES] = '{0, 3, 4, 5, 8, 9, 10, 13, 14, 17, 18};
  localparam int PH2_BIT [MUX_LINES] = '{20, 1, 2, 21, 6, 7, 19, 11, 12, 16, 15};

  // ==========================================================
  // register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0C;
  localparam logic CTRL_RST = 1'b0;

  // ==========================================================
  // types
  typedef struct packed {
    logic trm;
    logic ext;
    logic dll;
    logic mx;
    logic [1:0] bst;
    logic [2:0] cfg;
  } mrm_mode_t;
  localparam mrm_mode_t MODE_RST = '0;

  typedef struct packed {
    logic [3:0] rcy;
    logic [3:0] rl;
    logic [3:0] wl;
  } mrm_lat_t;

  typedef enum logic [1:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_REFRESH} mrm_kind_t;
  typedef enum logic {ST_IDLE, ST_PH2} mrm_state_t;

  typedef struct packed {
    mrm_kind_t kind;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } mrm_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } mrm_pins_t;

  // ==========================================================
  // latency decode; reserved codes give zero
  function automatic mrm_lat_t mrm_decode_lat(input logic [2:0] cfg, input logic mx);
    mrm_lat_t l;
    logic [3:0] base;
    case (cfg)
      3'h0, 3'h1: base = 4'h4;
      3'h2: base = 4'h6;
      3'h3: base = 4'h8;
      3'h4: base = 4'h3;
      3'h5: base = 4'h5;
      default: base = 4'h0;
    endcase
    l.rcy = base;
    l.rl = (base == 4'h0) ? 4'h0 : base + {3'h0, mx};
    l.wl = (base == 4'h0) ? 4'h0 : l.rl + 4'h1;
    return l;
  endfunction : mrm_decode_lat

  // highest used address bit per burst length and organisation
  function automatic logic [4:0] mrm_addr_top(input logic [1:0] bst, input logic x18);
    logic [4:0] t;
    case (bst)
      BST_CODE_4: t = TOP_BST4;
      BST_CODE_8: t = TOP_BST8;
      default: t = TOP_BST2;
    endcase
    return t - {4'h0, x18};
  endfunction : mrm_addr_top

  // link cycles of data per burst
  function automatic logic [2:0] mrm_burst_cyc(input logic [1:0] bst);
    case (bst)
      BST_CODE_4: return 3'h2;
      BST_CODE_8: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : mrm_burst_cyc

endpackage : mrm_pkg

// ---- rtl/mrm_sync.sv ----
// mrm_sync: two flip-flop synchroniser for a vector of levels.
// assumes every bit is an independent level from another domain.
`timescale 1ns/10ps
`default_nettype none
module mrm_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule : mrm_sync
`default_nettype wire

// ---- rtl/mrm_timer.sv ----
// mrm_timer: loadable down counter advanced by a tick enable.
// assumes start and tick are on sys_clk; done pulses when it reaches zero.
`timescale 1ns/10ps
`default_nettype none
module mrm_timer
  import mrm_pkg::*;
#(
  parameter int W = TMR_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [W-1:0] len,
  input wire logic tick,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = len;
    end else if (tick && cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
      done_nxt = (cnt_r == W'(1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = (cnt_r != '0);
  assign done = done_r;
endmodule : mrm_timer
`default_nettype wire

// ---- rtl/mrm_mode_mux.sv ----
// mrm_mode_mux: mode register load decode, two phase address mux,
// loop lock wait, impedance update timing and termination switching.
// assumes command pins and the command clock are asynchronous to sys_clk
// and slow enough to be sampled; registers sit on an AHB-Lite slave.
//
// Operation
// R1: mux mode config code is second-phase 4, 3 and first-phase 0.
// R2: write latency equals read latency plus one.
// R3: multiplexed address mode adds one cycle to both latencies.
// R4: controller keeps three-cycle row cycle, four for write then read.
// R5: controller never picks burst eight with configuration 1 or 4.
// R6: controller drives address 10 to 18 low in a mux load.
// R7: mux load ignores second-phase line 8 and the bank bits.
// R8: mux load takes mode bits from the documented first and second lines.
// R9: burst lengths 2, 4 and 8 from the burst field.
// R10: used address width shrinks with burst length and wider organisation.
// R11: controller treats data as stale after a burst length change.
// R12: loop starts off; 1024 clocks of lock before any read.
// R13: controller relocks by loading loop low, settle, high, then wait.
// R14: external impedance matching resamples the resistor periodically.
// R15: impedance bit low gives internal 50 ohm, still updated periodically.
// R16: mux access takes bank and first phase, second phase next edge.
// R17: refresh needs only the bank, one cycle, may run back to back.
// R18: mux mode carries addresses on eleven lines over two edges.
// R19: mux line to address bit map for each phase.
// R20: termination only on data in, data out and write mask.
// R21: output termination off while read data drive, inputs always on.
// R22: controller loads the mode register only with all banks idle.
// R23: load with bit 5 high enters mux mode after the settle time.
// R24: flat mode config on lines 2 to 0, latency one lower.
// R25: decoded mode held between loads, applied after settle time.
`timescale 1ns/10ps
`default_nettype none
module mrm_mode_mux
  import mrm_pkg::*;
#(
  parameter int IMP_CYC = IMP_PERIOD_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [BANK_W-1:0] bank_select_bits,
  input wire logic [ADDR_W-1:0] addr_pin,
  output var mrm_mode_t mode_o,
  output var mrm_lat_t lat_o,
  output var mrm_cmd_t cmd_o,
  output logic cmd_valid,
  output logic [4:0] addr_top_o,
  output logic dll_locked,
  output logic imp_ext_sel,
  output logic imp_update,
  output logic q_drive,
  output logic term_d_on,
  output logic term_wm_on,
  output logic term_q_on
);
  localparam int PIN_W = $bits(mrm_pins_t);

  // ==========================================================
  // pin synchronisers and command clock edge
  logic [PIN_W:0] s_out;
  mrm_pins_t pin_s;
  mrm_pins_t pin_d_r;
  logic clk_s;
  logic clk_d_r;
  logic link_rise;

  mrm_sync #(.W(PIN_W + 1)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d({link_clk, cs_n, we_n, ref_n, bank_select_bits, addr_pin}),
    .q(s_out)
  );
  assign {clk_s, pin_s} = s_out;

  // pins are taken one sample before the seen edge so they stand settled
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_d_r <= 1'b0;
      pin_d_r <= '1;
    end else begin
      clk_d_r <= clk_s;
      pin_d_r <= pin_s;
    end
  end
  assign link_rise = clk_s & ~clk_d_r;

  logic sel;
  logic is_ld;
  logic is_rd;
  logic is_wr;
  logic is_ref;
  assign sel = link_rise & ~pin_d_r.cs_n;
  assign is_ld = sel & ~pin_d_r.we_n & ~pin_d_r.ref_n;
  assign is_rd = sel & pin_d_r.we_n & pin_d_r.ref_n;
  assign is_wr = sel & ~pin_d_r.we_n & pin_d_r.ref_n;
  assign is_ref = sel & pin_d_r.we_n & ~pin_d_r.ref_n;

  // ==========================================================
  // applied mode and settle state
  mrm_mode_t mode_r;
  mrm_mode_t mode_nxt;
  mrm_mode_t new_mode_r;
  mrm_mode_t new_mode_nxt;
  mrm_lat_t lat_r;
  mrm_lat_t lat_nxt;
  logic load_r;
  logic load_nxt;
  logic ctrl_x18_r;
  logic set_busy;
  logic set_done;

  // ==========================================================
  // two phase address assembly
  mrm_state_t st_r;
  mrm_state_t st_nxt;
  logic [ADDR_W-1:0] hold_raw_r;
  logic [ADDR_W-1:0] hold_raw_nxt;
  logic [BANK_W-1:0] hold_bank_r;
  logic [BANK_W-1:0] hold_bank_nxt;
  mrm_kind_t hold_kind_r;
  mrm_kind_t hold_kind_nxt;
  logic hold_ld_r;
  logic hold_ld_nxt;
  mrm_cmd_t cmd_r;
  mrm_cmd_t cmd_nxt;
  logic cmd_valid_r;
  logic cmd_valid_nxt;
  wire [ADDR_W-1:0] mux_addr;
  logic [4:0] top;
  logic [ADDR_W:0] mask_w;
  logic [ADDR_W-1:0] addr_mask;
  mrm_mode_t nm_flat;
  mrm_mode_t nm_mux;

  // R19 line to bit map
  // R18 eleven line split
  for (genvar g = 0; g < MUX_LINES; g++) begin : g_map
    assign mux_addr[PH1_BIT[g]] = hold_raw_r[PH1_BIT[g]];
    assign mux_addr[PH2_BIT[g]] = pin_d_r.addr[PH1_BIT[g]];
  end

  // R10 burst sets width
  assign top = mrm_addr_top(mode_r.bst, ctrl_x18_r);
  assign mask_w = ((ADDR_W + 1)'(1) << (top + 5'h01)) - (ADDR_W + 1)'(1);
  assign addr_mask = mask_w[ADDR_W-1:0];

  always_comb begin
    // R24 flat load decode
    nm_flat.cfg = pin_d_r.addr[2:0];
    nm_flat.bst = pin_d_r.addr[M_BST+1:M_BST];
    nm_flat.mx = pin_d_r.addr[M_MX];
    nm_flat.dll = pin_d_r.addr[M_DLL];
    nm_flat.ext = pin_d_r.addr[M_EXT];
    nm_flat.trm = pin_d_r.addr[M_TRM];
    // R8 mux load mapping
    // R1 config from both phases
    // R7 line 8 and bank ignored
    nm_mux.cfg = {pin_d_r.addr[P2_M2], pin_d_r.addr[P2_M1], hold_raw_r[0]};
    nm_mux.bst = hold_raw_r[M_BST+1:M_BST];
    nm_mux.mx = hold_raw_r[M_MX];
    nm_mux.dll = pin_d_r.addr[P2_M7];
    nm_mux.ext = hold_raw_r[M_EXT];
    nm_mux.trm = hold_raw_r[M_TRM];
  end

  always_comb begin
    st_nxt = st_r;
    hold_raw_nxt = hold_raw_r;
    hold_bank_nxt = hold_bank_r;
    hold_kind_nxt = hold_kind_r;
    hold_ld_nxt = hold_ld_r;
    cmd_nxt = cmd_r;
    cmd_valid_nxt = 1'b0;
    load_nxt = 1'b0;
    new_mode_nxt = new_mode_r;
    case (st_r)
      ST_IDLE: begin
        if (is_ref) begin
          // R17 single cycle refresh
          cmd_nxt.kind = CMD_REFRESH;
          cmd_nxt.bank = pin_d_r.bank;
          cmd_nxt.addr = '0;
          cmd_valid_nxt = 1'b1;
        end else if ((is_rd | is_wr | is_ld) && mode_r.mx) begin
          // R16 first phase with bank
          st_nxt = ST_PH2;
          hold_raw_nxt = pin_d_r.addr;
          hold_bank_nxt = pin_d_r.bank;
          hold_kind_nxt = is_rd ? CMD_READ : CMD_WRITE;
          hold_ld_nxt = is_ld;
        end else if (is_rd | is_wr) begin
          cmd_nxt.kind = is_rd ? CMD_READ : CMD_WRITE;
          cmd_nxt.bank = pin_d_r.bank;
          cmd_nxt.addr = pin_d_r.addr & addr_mask;
          cmd_valid_nxt = 1'b1;
        end else if (is_ld) begin
          load_nxt = 1'b1;
          new_mode_nxt = nm_flat;
        end
      end
      ST_PH2: begin
        if (link_rise) begin
          // R16 second phase next edge
          st_nxt = ST_IDLE;
          if (hold_ld_r) begin
            load_nxt = 1'b1;
            new_mode_nxt = nm_mux;
          end else begin
            cmd_nxt.kind = hold_kind_r;
            cmd_nxt.bank = hold_bank_r;
            cmd_nxt.addr = mux_addr & addr_mask;
            cmd_valid_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= ST_IDLE;
      hold_raw_r <= '0;
      hold_bank_r <= '0;
      hold_kind_r <= CMD_NOP;
      hold_ld_r <= 1'b0;
      cmd_r <= '0;
      cmd_valid_r <= 1'b0;
      load_r <= 1'b0;
      new_mode_r <= MODE_RST;
    end else begin
      st_r <= st_nxt;
      hold_raw_r <= hold_raw_nxt;
      hold_bank_r <= hold_bank_nxt;
      hold_kind_r <= hold_kind_nxt;
      hold_ld_r <= hold_ld_nxt;
      cmd_r <= cmd_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      load_r <= load_nxt;
      new_mode_r <= new_mode_nxt;
    end
  end

  // ==========================================================
  // settle, loop lock and impedance timers
  logic lock_busy;
  logic lock_done;
  logic dll_start;
  logic locked_r;
  logic locked_nxt;
  logic imp_busy;

  // R25 apply after settle
  mrm_timer u_settle (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(load_r),
    .len(TMR_W'(SETTLE_CYC)),
    .tick(link_rise),
    .busy(set_busy),
    .done(set_done)
  );

  // R12 lock wait count
  assign dll_start = set_done & new_mode_r.dll & ~mode_r.dll;
  mrm_timer u_lock (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(dll_start),
    .len(TMR_W'(DLL_LOCK_CYC)),
    .tick(link_rise),
    .busy(lock_busy),
    .done(lock_done)
  );

  // R14 periodic resistor sample
  // R15 internal impedance update
  mrm_timer u_imp (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(~imp_busy),
    .len(TMR_W'(IMP_CYC)),
    .tick(1'b1),
    .busy(imp_busy),
    .done(imp_update)
  );

  always_comb begin
    // R25 hold between loads
    // R23 mux mode after settle
    mode_nxt = set_done ? new_mode_r : mode_r;
    // R2 write one over read
    // R3 mux adds one
    lat_nxt = mrm_decode_lat(mode_nxt.cfg, mode_nxt.mx);
    locked_nxt = locked_r;
    if (set_done && !new_mode_r.dll) begin
      locked_nxt = 1'b0;
    end else if (lock_done && mode_r.dll) begin
      locked_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= MODE_RST;
      lat_r <= mrm_decode_lat(MODE_RST.cfg, MODE_RST.mx);
      locked_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      lat_r <= lat_nxt;
      locked_r <= locked_nxt;
    end
  end

  // ==========================================================
  // read data window and termination
  logic [3:0] rd_wait_r;
  logic [3:0] rd_wait_nxt;
  logic [2:0] rd_left_r;
  logic [2:0] rd_left_nxt;

  always_comb begin
    rd_wait_nxt = rd_wait_r;
    rd_left_nxt = rd_left_r;
    if (link_rise) begin
      if (rd_wait_r != 4'h0) begin
        rd_wait_nxt = rd_wait_r - 4'h1;
        if (rd_wait_r == 4'h1) begin
          // R9 burst length cycles
          rd_left_nxt = mrm_burst_cyc(mode_r.bst);
        end
      end else if (rd_left_r != 3'h0) begin
        rd_left_nxt = rd_left_r - 3'h1;
      end
    end
    if (cmd_valid_r && cmd_r.kind == CMD_READ) begin
      rd_wait_nxt = lat_r.rl - {3'h0, mode_r.mx};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_wait_r <= 4'h0;
      rd_left_r <= 3'h0;
    end else begin
      rd_wait_r <= rd_wait_nxt;
      rd_left_r <= rd_left_nxt;
    end
  end

  // R20 data and mask terminated
  assign term_d_on = mode_r.trm;
  assign term_wm_on = mode_r.trm;
  // R21 outputs unterminated while driving
  assign q_drive = (rd_left_r != 3'h0);
  assign term_q_on = mode_r.trm & ~q_drive;

  // ==========================================================
  // AHB-Lite register slave, zero wait states
  logic ap;
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic ctrl_x18_nxt;
  logic early_r;
  logic early_nxt;
  logic early_set;
  logic cfg_rsv;

  assign ap = hsel & hready & htrans[1];
  assign cfg_rsv = (lat_r.rl == 4'h0);
  // R12 read before lock flagged
  assign early_set = cmd_valid_r & (cmd_r.kind == CMD_READ) & ~locked_r;

  always_comb begin
    wr_pend_nxt = ap & hwrite;
    wr_addr_nxt = ap ? haddr[7:0] : wr_addr_r;
    hrdata_nxt = hrdata_r;
    if (ap && !hwrite) begin
      case (haddr[7:0])
        REG_STATUS: hrdata_nxt = {8'h00, lat_r, cfg_rsv, locked_r, set_busy, mode_r};
        REG_CTRL: hrdata_nxt = {31'h00000000, ctrl_x18_r};
        REG_FLAGS: hrdata_nxt = {31'h00000000, early_r};
        REG_LAST: hrdata_nxt = {5'h00, cmd_r};
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
    ctrl_x18_nxt = ctrl_x18_r;
    if (wr_pend_r && wr_addr_r == REG_CTRL) begin
      ctrl_x18_nxt = hwdata[0];
    end
    early_nxt = early_set | (early_r & ~(wr_pend_r && wr_addr_r == REG_FLAGS && hwdata[0]));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      ctrl_x18_r <= CTRL_RST;
      early_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_x18_r <= ctrl_x18_nxt;
      early_r <= early_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign mode_o = mode_r;
  assign lat_o = lat_r;
  assign cmd_o = cmd_r;
  assign cmd_valid = cmd_valid_r;
  assign addr_top_o = top;
  assign dll_locked = locked_r;
  assign imp_ext_sel = mode_r.ext;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic [TMR_W-1:0] lk_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (srst || dll_start) begin
      lk_cnt_r <= '0;
    end else if (link_rise && lock_busy) begin
      lk_cnt_r <= lk_cnt_r + TMR_W'(1);
    end
  end

  sequence s_mux_rw;
    st_r == ST_IDLE && (is_rd || is_wr) && mode_r.mx;
  endsequence
  sequence s_ph2_out;
    cmd_valid_r && (cmd_r.kind == CMD_READ || cmd_r.kind == CMD_WRITE);
  endsequence

  a_wl_over_rl: assert property (!cfg_rsv |-> lat_r.wl == lat_r.rl + 4'h1) // R2
    else $error("write latency not read latency plus one");
  a_mux_cfg3_lat: assert property (mode_r.mx && mode_r.cfg == 3'h3 |-> lat_r.rl == 4'h9 && lat_r.wl == 4'hA) // R3
    else $error("mux config 3 latency wrong");
  a_flat_cfg4_lat: assert property (!mode_r.mx && mode_r.cfg == 3'h4 |-> lat_r.rl == 4'h3 && lat_r.rcy == 4'h3) // R24
    else $error("flat config 4 latency wrong");
  a_mode_only_settled: assert property ($changed(mode_r) |-> $past(set_done)) // R25
    else $error("mode changed without settle");
  a_lock_count: assert property ($rose(locked_r) |-> lk_cnt_r == TMR_W'(DLL_LOCK_CYC)) // R12
    else $error("loop locked at wrong count");
  a_mux_two_phase: assert property (s_mux_rw |=> !cmd_valid_r [*2] ##[1:40] s_ph2_out) // R16
    else $error("second phase not used");
  a_refresh_single: assert property (st_r == ST_IDLE && is_ref |=> cmd_valid_r && cmd_r.kind == CMD_REFRESH) // R17
    else $error("refresh not single cycle");
  a_addr_in_width: assert property (cmd_valid_r |-> (cmd_r.addr & ~addr_mask) == '0) // R10
    else $error("address above burst width");
  a_q_term_off: assert property (mode_r.trm |-> term_q_on == !q_drive && term_d_on && term_wm_on) // R21
    else $error("output termination wrong");
  a_zq_gap: assert property (imp_update |=> !imp_update [*8]) // R14
    else $error("impedance update too frequent");

endmodule : mrm_mode_mux
`default_nettype wire

// ---- sim/mrm_ctl_model.sv ----
// mrm_ctl_model: memory controller model driving the command pins.
// assumes sys_clk paces it; the link clock runs only during commands.
`timescale 1ns/10ps
`default_nettype none
module mrm_ctl_model
  import mrm_pkg::*;
(
  input wire logic sys_clk,
  output logic link_clk,
  output logic cs_n,
  output logic we_n,
  output logic ref_n,
  output logic [BANK_W-1:0] bank_select_bits,
  output logic [ADDR_W-1:0] addr_pin
);
  initial begin
    link_clk = 1'b0;
    {cs_n, we_n, ref_n} = 3'h7;
    bank_select_bits = '0;
    addr_pin = '0;
  end
  // ==========================================================
  // one link cycle of 800 ns; command pins released high, bank and address inverted after the rise
  // phases on successive edges
  task automatic send(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
    {cs_n, we_n, ref_n} <= c;
    bank_select_bits <= b;
    addr_pin <= a;
    repeat (4) @(posedge sys_clk);
    link_clk <= 1'b1;
    repeat (2) @(posedge sys_clk);
    {cs_n, we_n, ref_n} <= 3'h7;
    bank_select_bits <= ~b;
    addr_pin <= ~a;
    repeat (2) @(posedge sys_clk);
    link_clk <= 1'b0;
  endtask : send
endmodule : mrm_ctl_model
`default_nettype wire

// ---- sim/mrm_mode_mux_tb.sv ----
// mrm_mode_mux_tb: self-checking bench of the mode register and address mux.
// assumes the controller model paces the link; the bench is the AHB master.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %0t %h %h", $time, g, e); end end
module mrm_mode_mux_tb
  import mrm_pkg::*;
;
  logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, link_clk, cs_n, we_n, ref_n, cmd_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr, e;
  mrm_mode_t mode;
  mrm_lat_t lat;
  mrm_cmd_t cmd;
  logic [4:0] top;
  logic locked, ext_sel, imp_up, q_drive, t_d, t_wm, t_q;
  int mismatches = 0, checks = 0, nval = 0, nimp = 0, nq = 0, badq = 0, n0;
  localparam int BASE [6] = '{4, 4, 6, 8, 3, 5};
  // ==========================================================
  // clock, instances, monitors
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  mrm_mode_mux #(.IMP_CYC(20)) dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk), .cs_n(cs_n),
    .we_n(we_n), .ref_n(ref_n), .bank_select_bits(bank), .addr_pin(addr), .mode_o(mode),
    .lat_o(lat), .cmd_o(cmd), .cmd_valid(cmd_valid), .addr_top_o(top), .dll_locked(locked),
    .imp_ext_sel(ext_sel), .imp_update(imp_up), .q_drive(q_drive), .term_d_on(t_d),
    .term_wm_on(t_wm), .term_q_on(t_q));
  mrm_ctl_model ctl (.sys_clk(sys_clk), .link_clk(link_clk), .cs_n(cs_n), .we_n(we_n),
    .ref_n(ref_n), .bank_select_bits(bank), .addr_pin(addr));
  always @(posedge sys_clk) begin
    nval <= nval + (cmd_valid === 1'b1);
    nimp <= nimp + (imp_up === 1'b1);
    nq <= nq + (q_drive === 1'b1);
    badq <= badq + (q_drive === 1'b1 && (t_q !== 1'b0 || t_d !== mode.trm));
  end
  // ==========================================================
  // bus and link helpers
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic wrdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 9);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask : wrdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    rd = hrdata;
  endtask : ahb
  task automatic nops(input int n);
    repeat (n) ctl.send(3'h7, '0, '0);
  endtask : nops
  task automatic mload(input logic [ADDR_W-1:0] p1, input logic [ADDR_W-1:0] p2);
    ctl.send(3'h0, 3'h5, p1);
    ctl.send(3'h7, '0, p2);
    nops(7);
  endtask : mload
  // ==========================================================
  // scenarios
  task automatic t_cfg();
    for (int c = 0; c < 7; c++) begin
      ctl.send(3'h0, '0, ADDR_W'(c));
      `CHK(mode.cfg, 3'((c == 0) ? 0 : c - 1))
      nops(7);
      `CHK(lat, (c == 6) ? 12'h0 : {4'(BASE[c]), 4'(BASE[c]), 4'(BASE[c] + 1)})
    end
  endtask : t_cfg
  task automatic t_bl();
    for (int b = 0; b < 3; b++) begin
      ctl.send(3'h0, '0, ADDR_W'((b << 3) | 2));
      nops(7);
      `CHK(top, 5'(21 - b))
    end
    ahb(1'b1, REG_CTRL, 32'h1);
    @(posedge sys_clk);
    `CHK(top, 5'h12)
    ahb(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    ahb(1'b1, REG_CTRL, 32'h0);
  endtask : t_bl
  task automatic t_mux();
    ctl.send(3'h0, '0, 22'h20);
    nops(7);
    `CHK(mode.mx, 1'b1)
    mload(22'h229, 22'h108);
    `CHK(mode, 9'h12B)
    ahb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[23:0], 24'h89A12B)
  endtask : t_mux
  task automatic t_acc();
    n0 = nval;
    ctl.send(3'h3, 3'h5, 22'h3FFFFF);
    ctl.send(3'h7, '0, 22'h155555);
    e = '0;
    for (int k = 0; k < MUX_LINES; k++) begin
      e[PH1_BIT[k]] = 1'b1;
      e[PH2_BIT[k]] = (PH1_BIT[k] % 2) == 0;
    end
    e[21] = 1'b0;
    nops(12);
    `CHK(nval - n0, 1)
    `CHK(cmd, {CMD_READ, 3'h5, e})
    `CHK(nq > 0 && badq == 0, 1'b1)
    `CHK({t_d, t_wm}, 2'h3)
    `CHK(t_q, 1'b1)
    ahb(1'b0, REG_FLAGS, 32'h0);
    `CHK(rd, 32'h1)
    ahb(1'b1, REG_FLAGS, 32'h1);
    ahb(1'b0, REG_FLAGS, 32'h0);
    `CHK(rd, 32'h0)
  endtask : t_acc
  task automatic t_ref();
    n0 = nval;
    repeat (3) ctl.send(3'h2, 3'h6, '0);
    nops(1);
    `CHK(nval - n0, 3)
    `CHK(cmd[26:22], {CMD_REFRESH, 3'h6})
    ahb(1'b0, REG_LAST, 32'h0);
    `CHK(rd, {5'h00, CMD_REFRESH, 3'h6, 22'h000000})
  endtask : t_ref
  task automatic t_dll();
    mload(22'h329, 22'h208);
    `CHK(ext_sel, 1'b1)
    nops(1015);
    `CHK(locked, 1'b0)
    nops(12);
    `CHK(locked, 1'b1)
    mload(22'h229, 22'h008);
    `CHK({locked, ext_sel}, 2'h0)
    n0 = nimp;
    repeat (210) @(posedge sys_clk);
    `CHK(nimp - n0, 10)
  endtask : t_dll
  // ==========================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    `CHK({lat, hresp}, 13'h88A)
    t_cfg();
    t_bl();
    t_mux();
    t_acc();
    t_ref();
    t_dll();
    results();
  end
  initial begin
    #5000000;
    mismatches++;
    results();
  end
endmodule : mrm_mode_mux_tb
`default_nettype wire
